// ==== mac_stats_counter.sv ====
// Downstream packet and error counter fed by one statistics vector
`timescale 1ns/100ps
`default_nettype none
module mac_stats_counter (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Statistics vector
  input  wire logic [39:0] stats_vector_i,
  // Counters
  output logic      [31:0] pkt_count_o,
  output logic      [31:0] err_count_o
);
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pkt_count_o <= 32'h0;
      err_count_o <= 32'h0;
    end
    else if (stats_vector_i[31])
    begin
      pkt_count_o <= pkt_count_o + 32'h1;
      err_count_o <= err_count_o + {31'h0, stats_vector_i[23]};
    end
  end
endmodule
`default_nettype wire

// ==== mac_stats_pkg.sv ====
// Constants and types shared by the statistics vector generator
`default_nettype none
package mac_stats_pkg;

  // Vector layout
  localparam int VEC_W      = 40;
  localparam int CH_HI      = 39;
  localparam int CH_LO      = 32;
  localparam int PKT_EN_BIT = 31;
  localparam int PKT_OK_BIT = 30;
  localparam int CLASS_HI   = 29;
  localparam int CLASS_LO   = 24;
  localparam int ERR_BIT    = 23;
  localparam int SPARE_HI   = 22;
  localparam int SPARE_LO   = 21;
  localparam int ERRS_HI    = 20;
  localparam int ERRS_LO    = 16;
  localparam int LEN_HI     = 15;
  localparam int LEN_LO     = 0;

  // Error detail positions inside the five-bit error group
  localparam int E_FRM   = 4;
  localparam int E_FCS   = 3;
  localparam int E_SHORT = 2;
  localparam int E_CHECK = 1;
  localparam int E_LONG  = 0;

  // Length arithmetic
  localparam logic [15:0] MIN_PKT_LEN  = 16'h0040;
  localparam logic [15:0] LT_TYPE_MIN  = 16'h0600;
  localparam logic [15:0] HDR_FCS_LEN  = 16'h0012;
  localparam logic [15:0] VLAN_TAG_LEN = 16'h0004;
  localparam logic [15:0] MIN_PAYLOAD  = 16'h002E;

  // Register offsets
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  CTRL_ADDR    = 8'h00;
  localparam logic [7:0]  TX_MAX_ADDR  = 8'h04;
  localparam logic [7:0]  RX_MAX_ADDR  = 8'h08;
  localparam logic [7:0]  IRQ_ST_ADDR  = 8'h0C;
  localparam logic [7:0]  IRQ_MSK_ADDR = 8'h10;
  localparam logic [7:0]  FAULT_ADDR   = 8'h14;
  localparam logic [7:0]  BUILD_ADDR   = 8'h18;

  // Reset values
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [15:0] MAX_LEN_RST  = 16'h05EE;
  localparam logic [4:0]  IRQ_MSK_RST  = 5'h00;

  // Control bits
  localparam int CTRL_W            = 4;
  localparam int CTRL_TX_FCS_ERR   = 0;
  localparam int CTRL_FORCE_LOCAL  = 1;
  localparam int CTRL_FORCE_REMOTE = 2;
  localparam int CTRL_FORCE_IDLE   = 3;

  // Interrupt bits
  localparam int IRQ_W      = 5;
  localparam int IRQ_TX_PKT = 0;
  localparam int IRQ_RX_PKT = 1;
  localparam int IRQ_TX_ERR = 2;
  localparam int IRQ_RX_ERR = 3;
  localparam int IRQ_FAULT  = 4;

  // Build defaults
  localparam int WORD_BYTES            = 4;
  localparam int SWC_DEFAULT           = 2;
  localparam int CWC_DEFAULT           = 1;
  localparam int TX_FIFO_DEPTH_DEFAULT = 32;
  localparam int PREAMBLE_W            = 56;

  // Transmit fault state, Gray along none, idle, remote, local
  typedef enum logic [1:0] {
    FAULT_NONE   = 2'b00,
    FAULT_IDLE   = 2'b01,
    FAULT_REMOTE = 2'b11,
    FAULT_LOCAL  = 2'b10
  } fault_state_type;

endpackage
`default_nettype wire

// ==== mac_stats_vector_gen.sv ====
// Per-packet statistics vector generator for transmit and receive
//
// What this block does
// - Channel identifier sits in bits 39:32; zero for a single instance.
// - Bit 31 pulses once per packet and qualifies flags in bits 30:24.
// - Summary error in bit 23, bits 22:21 spare, error details in 20:16.
// - Packet length sits in bits 15:0, valid with bit 31.
// - Transmit and receive vectors share one bit layout.
// - Statistics leave as vector outputs only; no register mirrors them.
// - Transmit framing error: user FCS-error request, protocol error, underrun, overflow.
// - Receive framing error when delineation marks the packet bad.
// - Length-short error for packets below 64 bytes.
// - Length-check error when length field mismatches; disabled by build parameter.
// - Length-long error when packet exceeds that direction's maximum length.
// - Transmit fault state chosen by priority: local, remote, then idle.
// - System word count accepts 1 or 2 four-byte words.
// - Core word count 1 or 2 words, default one.
// - Transmit FIFO depth is a build parameter, default 32.
// - Custom preamble active only when its build parameter is 1.
// - Transmit length check touches statistics only.
// - Receive length check touches datapath and statistics.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module mac_stats_vector_gen #(
  parameter int          SYSTEM_WORD_COUNT  = mac_stats_pkg::SWC_DEFAULT,
  parameter int          CORE_WORD_COUNT    = mac_stats_pkg::CWC_DEFAULT,
  parameter int          TX_FIFO_DEPTH      = mac_stats_pkg::TX_FIFO_DEPTH_DEFAULT,
  parameter bit          TX_CUSTOM_PREAMBLE = 1'b0,
  parameter bit          TX_LENGTH_FIELD_CHECK = 1'b0,
  parameter bit          RX_LENGTH_FIELD_CHECK = 1'b0,
  parameter logic [7:0]  STAT_CHANNEL_ID    = 8'h00
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Transmit packet report
  input  wire logic        tx_pkt_done_i,
  input  wire logic [15:0] tx_pkt_len_i,
  input  wire logic [15:0] tx_len_type_i,
  input  wire logic [5:0]  tx_pkt_class_i,
  input  wire logic        tx_fcs_err_i,
  input  wire logic        tx_proto_err_i,
  input  wire logic        tx_underrun_i,
  input  wire logic        tx_overflow_i,
  // Receive packet report
  input  wire logic        rx_pkt_done_i,
  input  wire logic [15:0] rx_pkt_len_i,
  input  wire logic [15:0] rx_len_type_i,
  input  wire logic [5:0]  rx_pkt_class_i,
  input  wire logic        rx_fcs_err_i,
  input  wire logic        rx_delin_err_i,
  // Fault sources
  input  wire logic        local_fault_i,
  input  wire logic        remote_fault_i,
  input  wire logic        idle_req_i,
  // Custom preamble
  input  wire logic [55:0] tx_preamble_i,
  output logic      [55:0] tx_preamble_o,
  output logic             tx_preamble_en_o,
  // Statistics and status
  output logic      [39:0] tx_stats_vector_o,
  output logic      [39:0] rx_stats_vector_o,
  output logic             rx_len_drop_o,
  output logic      [1:0]  tx_fault_state_o,
  output logic             irq_o
);

  // Build checks
  if (SYSTEM_WORD_COUNT < 1 || SYSTEM_WORD_COUNT > 2)
  begin : g_bad_swc
    $error("system word count must be 1 or 2");
  end
  if (CORE_WORD_COUNT < 1 || CORE_WORD_COUNT > 2)
  begin : g_bad_cwc
    $error("core word count must be 1 or 2");
  end
  if (TX_FIFO_DEPTH < 2 || TX_FIFO_DEPTH > 65535)
  begin : g_bad_depth
    $error("transmit fifo depth out of range");
  end

  localparam logic [3:0]  SYS_BYTES  = 4'(SYSTEM_WORD_COUNT * mac_stats_pkg::WORD_BYTES);
  localparam logic [3:0]  CORE_BYTES = 4'(CORE_WORD_COUNT * mac_stats_pkg::WORD_BYTES);
  localparam logic [15:0] FIFO_DEPTH = 16'(TX_FIFO_DEPTH);

  // Length field compared against the real data length
  function automatic logic len_mismatch(
    input logic [15:0] pkt_len,
    input logic [15:0] len_type,
    input logic        vlan
  );
    logic [15:0] overhead;
    logic [15:0] data_len;
    begin
      overhead = mac_stats_pkg::HDR_FCS_LEN + (vlan ? mac_stats_pkg::VLAN_TAG_LEN : 16'h0000);
      data_len = pkt_len - overhead;
      if (len_type >= mac_stats_pkg::LT_TYPE_MIN)
        len_mismatch = 1'b0;
      else if (pkt_len < overhead)
        len_mismatch = 1'b1;
      else if (len_type < mac_stats_pkg::MIN_PAYLOAD)
        len_mismatch = (data_len != mac_stats_pkg::MIN_PAYLOAD);
      else
        len_mismatch = (data_len != len_type);
    end
  endfunction

  // Shared vector packing for both directions
  function automatic logic [39:0] make_vector(
    input logic [5:0]  pkt_class,
    input logic [4:0]  errs,
    input logic [15:0] pkt_len
  );
    logic [39:0] v;
    begin
      v = '0;
      v[mac_stats_pkg::CH_HI:mac_stats_pkg::CH_LO] = STAT_CHANNEL_ID;
      v[mac_stats_pkg::PKT_EN_BIT] = 1'b1;
      v[mac_stats_pkg::PKT_OK_BIT] = ~|errs;
      v[mac_stats_pkg::CLASS_HI:mac_stats_pkg::CLASS_LO] = pkt_class;
      v[mac_stats_pkg::ERR_BIT] = |errs;
      v[mac_stats_pkg::SPARE_HI:mac_stats_pkg::SPARE_LO] = 2'b00;
      v[mac_stats_pkg::ERRS_HI:mac_stats_pkg::ERRS_LO] = errs;
      v[mac_stats_pkg::LEN_HI:mac_stats_pkg::LEN_LO] = pkt_len;
      make_vector = v;
    end
  endfunction

  // Reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Registers
  logic [3:0]                   ctrl;
  logic [15:0]                  tx_max_len;
  logic [15:0]                  rx_max_len;
  logic [4:0]                   irq_status;
  logic [4:0]                   irq_mask;
  mac_stats_pkg::fault_state_type fault_state;
  mac_stats_pkg::fault_state_type next_fault_state;

  logic wr_ctrl;
  logic wr_tx_max;
  logic wr_rx_max;
  logic wr_irq_st;
  logic wr_irq_msk;

  assign wr_ctrl    = reg_wr_i && (reg_addr_i == mac_stats_pkg::CTRL_ADDR);
  assign wr_tx_max  = reg_wr_i && (reg_addr_i == mac_stats_pkg::TX_MAX_ADDR);
  assign wr_rx_max  = reg_wr_i && (reg_addr_i == mac_stats_pkg::RX_MAX_ADDR);
  assign wr_irq_st  = reg_wr_i && (reg_addr_i == mac_stats_pkg::IRQ_ST_ADDR);
  assign wr_irq_msk = reg_wr_i && (reg_addr_i == mac_stats_pkg::IRQ_MSK_ADDR);

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl       <= mac_stats_pkg::CTRL_RST;
      tx_max_len <= mac_stats_pkg::MAX_LEN_RST;
      rx_max_len <= mac_stats_pkg::MAX_LEN_RST;
      irq_mask   <= mac_stats_pkg::IRQ_MSK_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= reg_wdata_i[3:0];
      if (wr_tx_max)
        tx_max_len <= reg_wdata_i[15:0];
      if (wr_rx_max)
        rx_max_len <= reg_wdata_i[15:0];
      if (wr_irq_msk)
        irq_mask <= reg_wdata_i[4:0];
    end
  end

  // Transmit framing errors seen during the packet, held until its end
  logic tx_frm_pend;
  logic tx_frm_now;

  assign tx_frm_now = tx_proto_err_i | tx_underrun_i | tx_overflow_i;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tx_frm_pend <= 1'b0;
    else if (tx_pkt_done_i)
      tx_frm_pend <= 1'b0;
    else if (tx_frm_now)
      tx_frm_pend <= 1'b1;
  end

  // Transmit error classification
  logic [4:0] tx_errs;

  always_comb
  begin
    tx_errs = '0;
    tx_errs[mac_stats_pkg::E_FRM] = ctrl[mac_stats_pkg::CTRL_TX_FCS_ERR] | tx_frm_pend
                                    | tx_frm_now;
    tx_errs[mac_stats_pkg::E_FCS] = tx_fcs_err_i;
    tx_errs[mac_stats_pkg::E_SHORT] = tx_pkt_len_i < mac_stats_pkg::MIN_PKT_LEN;
    tx_errs[mac_stats_pkg::E_CHECK] = TX_LENGTH_FIELD_CHECK
        && len_mismatch(tx_pkt_len_i, tx_len_type_i, tx_pkt_class_i[4]);
    tx_errs[mac_stats_pkg::E_LONG] = tx_pkt_len_i > tx_max_len;
  end

  // Receive error classification
  logic [4:0] rx_errs;

  always_comb
  begin
    rx_errs = '0;
    rx_errs[mac_stats_pkg::E_FRM] = rx_delin_err_i;
    rx_errs[mac_stats_pkg::E_FCS] = rx_fcs_err_i;
    rx_errs[mac_stats_pkg::E_SHORT] = rx_pkt_len_i < mac_stats_pkg::MIN_PKT_LEN;
    rx_errs[mac_stats_pkg::E_CHECK] = RX_LENGTH_FIELD_CHECK
        && len_mismatch(rx_pkt_len_i, rx_len_type_i, rx_pkt_class_i[4]);
    rx_errs[mac_stats_pkg::E_LONG] = rx_pkt_len_i > rx_max_len;
  end

  // Transmit vector, one cycle per packet, no datapath effect
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tx_stats_vector_o <= '0;
    else if (tx_pkt_done_i)
      tx_stats_vector_o <= make_vector(tx_pkt_class_i, tx_errs, tx_pkt_len_i);
    else
      tx_stats_vector_o <= '0;
  end

  // Receive vector, one cycle per packet
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rx_stats_vector_o <= '0;
    else if (rx_pkt_done_i)
      rx_stats_vector_o <= make_vector(rx_pkt_class_i, rx_errs, rx_pkt_len_i);
    else
      rx_stats_vector_o <= '0;
  end

  // Receive length check also marks the packet for the datapath
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rx_len_drop_o <= 1'b0;
    else
      rx_len_drop_o <= rx_pkt_done_i && rx_errs[mac_stats_pkg::E_CHECK];
  end

  // Fault state by priority
  always_comb
  begin
    if (local_fault_i || ctrl[mac_stats_pkg::CTRL_FORCE_LOCAL])
      next_fault_state = mac_stats_pkg::FAULT_LOCAL;
    else if (remote_fault_i || ctrl[mac_stats_pkg::CTRL_FORCE_REMOTE])
      next_fault_state = mac_stats_pkg::FAULT_REMOTE;
    else if (idle_req_i || ctrl[mac_stats_pkg::CTRL_FORCE_IDLE])
      next_fault_state = mac_stats_pkg::FAULT_IDLE;
    else
      next_fault_state = mac_stats_pkg::FAULT_NONE;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      fault_state <= mac_stats_pkg::FAULT_NONE;
    else
    begin
      case (fault_state)
        mac_stats_pkg::FAULT_NONE,
        mac_stats_pkg::FAULT_IDLE,
        mac_stats_pkg::FAULT_REMOTE,
        mac_stats_pkg::FAULT_LOCAL:
          fault_state <= next_fault_state;
        default:
          fault_state <= mac_stats_pkg::FAULT_NONE;
      endcase
    end
  end

  assign tx_fault_state_o = fault_state;

  // Sticky interrupt status, set wins over clear
  logic [4:0] irq_set;

  always_comb
  begin
    irq_set = '0;
    irq_set[mac_stats_pkg::IRQ_TX_PKT] = tx_pkt_done_i;
    irq_set[mac_stats_pkg::IRQ_RX_PKT] = rx_pkt_done_i;
    irq_set[mac_stats_pkg::IRQ_TX_ERR] = tx_pkt_done_i && (|tx_errs);
    irq_set[mac_stats_pkg::IRQ_RX_ERR] = rx_pkt_done_i && (|rx_errs);
    irq_set[mac_stats_pkg::IRQ_FAULT]  = next_fault_state != fault_state;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_status <= '0;
    else if (wr_irq_st)
      irq_status <= (irq_status & ~reg_wdata_i[4:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_status & irq_mask);
  end

  // Custom preamble pass-through
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_preamble_o    <= '0;
      tx_preamble_en_o <= 1'b0;
    end
    else
    begin
      tx_preamble_o    <= TX_CUSTOM_PREAMBLE ? tx_preamble_i : '0;
      tx_preamble_en_o <= TX_CUSTOM_PREAMBLE;
    end
  end

  // Read data, valid only in the cycle after the strobe
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = '0;
    case (reg_addr_i)
      mac_stats_pkg::CTRL_ADDR:    next_rdata = {28'h0000000, ctrl};
      mac_stats_pkg::TX_MAX_ADDR:  next_rdata = {16'h0000, tx_max_len};
      mac_stats_pkg::RX_MAX_ADDR:  next_rdata = {16'h0000, rx_max_len};
      mac_stats_pkg::IRQ_ST_ADDR:  next_rdata = {27'h0000000, irq_status};
      mac_stats_pkg::IRQ_MSK_ADDR: next_rdata = {27'h0000000, irq_mask};
      mac_stats_pkg::FAULT_ADDR:   next_rdata = {30'h00000000, fault_state};
      mac_stats_pkg::BUILD_ADDR:
        next_rdata = {FIFO_DEPTH, 3'b000, RX_LENGTH_FIELD_CHECK, TX_LENGTH_FIELD_CHECK,
                      TX_CUSTOM_PREAMBLE, 2'b00, CORE_BYTES, SYS_BYTES};
      default:                     next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_o <= '0;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
    else
      reg_rdata_o <= '0;
  end

endmodule
`default_nettype wire

// ==== mac_stats_vector_gen_assertions.sv ====
// Port assertions for the statistics vector generator
`timescale 1ns/100ps
`default_nettype none
module mac_stats_vector_gen_assertions #(
  parameter bit         TX_CUSTOM_PREAMBLE = 1'b0,
  parameter logic [7:0] STAT_CHANNEL_ID    = 8'h00
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // Packet reports
  input wire logic        tx_pkt_done_i,
  input wire logic [15:0] tx_pkt_len_i,
  input wire logic        tx_proto_err_i,
  input wire logic        tx_underrun_i,
  input wire logic        tx_overflow_i,
  input wire logic        rx_pkt_done_i,
  input wire logic [15:0] rx_pkt_len_i,
  input wire logic        rx_delin_err_i,
  input wire logic        local_fault_i,
  // Outputs watched
  input wire logic [55:0] tx_preamble_o,
  input wire logic        tx_preamble_en_o,
  input wire logic [39:0] tx_stats_vector_o,
  input wire logic [39:0] rx_stats_vector_o,
  input wire logic        rx_len_drop_o,
  input wire logic [1:0]  tx_fault_state_o,
  input wire logic        irq_o
);
  default clocking dflt @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_tx_answer: assert property (tx_pkt_done_i |=> tx_stats_vector_o[31])
    else $error("tx vector missing after done");
  chk_idle_zero: assert property (!tx_pkt_done_i |=> tx_stats_vector_o == 40'h0)
    else $error("tx vector not zero outside report cycle");
  chk_rx_channel: assert property (rx_pkt_done_i |=> rx_stats_vector_o[39:31] == {STAT_CHANNEL_ID, 1'b1})
    else $error("rx vector channel or qualifier wrong");
  chk_err_summary: assert property (tx_stats_vector_o[31] |-> tx_stats_vector_o[23] == |tx_stats_vector_o[20:16] && tx_stats_vector_o[30] == !tx_stats_vector_o[23] && tx_stats_vector_o[22:21] == 2'h0)
    else $error("tx error summary inconsistent");
  chk_short_flag: assert property (tx_pkt_done_i |=> tx_stats_vector_o[18] == ($past(tx_pkt_len_i) < 16'h0040))
    else $error("tx short flag wrong");
  chk_len_carry: assert property (rx_pkt_done_i |=> rx_stats_vector_o[15:0] == $past(rx_pkt_len_i))
    else $error("rx length field wrong");
  chk_tx_framing: assert property (tx_pkt_done_i && (tx_proto_err_i || tx_underrun_i || tx_overflow_i) |=> tx_stats_vector_o[20])
    else $error("tx framing flag missing");
  chk_rx_framing: assert property (rx_pkt_done_i && rx_delin_err_i |=> rx_stats_vector_o[20])
    else $error("rx framing flag missing");
  chk_local_first: assert property (local_fault_i |=> tx_fault_state_o == 2'b10)
    else $error("local fault not preferred");
  chk_preamble_off: assert property (!TX_CUSTOM_PREAMBLE |-> tx_preamble_o == 56'h0 && !tx_preamble_en_o)
    else $error("preamble outputs active while disabled");
  chk_drop_check: assert property (rx_len_drop_o |-> rx_stats_vector_o[17] && rx_stats_vector_o[31])
    else $error("rx drop without length check error");

  cov_tx_err: cover property (tx_stats_vector_o[31] && tx_stats_vector_o[23]);
  cov_rx_long: cover property (rx_stats_vector_o[16]);
  cov_irq: cover property ($rose(irq_o));
endmodule

bind mac_stats_vector_gen mac_stats_vector_gen_assertions #(
  .TX_CUSTOM_PREAMBLE(TX_CUSTOM_PREAMBLE),
  .STAT_CHANNEL_ID(STAT_CHANNEL_ID)
) u_chk (.clk_i, .rstn_i, .tx_pkt_done_i, .tx_pkt_len_i, .tx_proto_err_i, .tx_underrun_i,
  .tx_overflow_i, .rx_pkt_done_i, .rx_pkt_len_i, .rx_delin_err_i, .local_fault_i, .tx_preamble_o,
  .tx_preamble_en_o, .tx_stats_vector_o, .rx_stats_vector_o, .rx_len_drop_o, .tx_fault_state_o,
  .irq_o);
`default_nettype wire

// ==== mac_stats_vector_gen_test.sv ====
// Self-checking bench for the statistics vector generator
`timescale 1ns/100ps
`default_nettype none
module mac_stats_vector_gen_test;
  logic        clk_i, rstn_i, reg_wr_i, reg_rd_i, tx_pkt_done_i, tx_fcs_err_i, tx_proto_err_i;
  logic        tx_underrun_i, tx_overflow_i, rx_pkt_done_i, rx_fcs_err_i, rx_delin_err_i;
  logic        local_fault_i, remote_fault_i, idle_req_i, tx_preamble_en_o, rx_len_drop_o;
  logic        irq_o, rd_seen, fcs_ins;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, tx_pkts, rx_pkts, state, n_tx, n_rx;
  logic [15:0] tx_pkt_len_i, tx_len_type_i, rx_pkt_len_i, rx_len_type_i, tx_max, rx_max;
  logic [5:0]  tx_pkt_class_i, rx_pkt_class_i;
  logic [55:0] tx_preamble_i, tx_preamble_o;
  logic [39:0] tx_stats_vector_o, rx_stats_vector_o;
  logic [1:0]  tx_fault_state_o, ltm;
  logic [39:0] txq[$], rxq[$];
  logic [31:0] rdq[$];
  int          mismatches, checks_done;

  mac_stats_vector_gen #(.TX_LENGTH_FIELD_CHECK(1'b1), .RX_LENGTH_FIELD_CHECK(1'b1))
    u_mac_stats_vector_gen (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .tx_pkt_done_i, .tx_pkt_len_i, .tx_len_type_i,
    .tx_pkt_class_i, .tx_fcs_err_i, .tx_proto_err_i, .tx_underrun_i, .tx_overflow_i,
    .rx_pkt_done_i, .rx_pkt_len_i, .rx_len_type_i, .rx_pkt_class_i, .rx_fcs_err_i,
    .rx_delin_err_i, .local_fault_i, .remote_fault_i, .idle_req_i, .tx_preamble_i,
    .tx_preamble_o, .tx_preamble_en_o, .tx_stats_vector_o, .rx_stats_vector_o, .rx_len_drop_o,
    .tx_fault_state_o, .irq_o);
  mac_stats_counter u_mac_stats_counter (.clk_i, .rstn_i, .stats_vector_i(tx_stats_vector_o),
    .pkt_count_o(tx_pkts), .err_count_o());
  mac_stats_counter u_mac_stats_counter_rx (.clk_i, .rstn_i, .stats_vector_i(rx_stats_vector_o),
    .pkt_count_o(rx_pkts), .err_count_o());

  always #5 clk_i = ~clk_i;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_vec(input logic [39:0] e, input logic [39:0] a);
    checks_done++;
    if (a !== e)
      $display("[FAIL] %0t vector %h expected %h", $time, a, e);
    if (a !== e)
      mismatches++;
  endtask

  task automatic chk_word(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e)
      $display("[FAIL] %0t value %h expected %h", $time, a, e);
    if (a !== e)
      mismatches++;
  endtask

  task automatic reg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= wr;
    reg_rd_i <= !wr;
    if (!wr)
      rdq.push_back(d);
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
  endtask

  task automatic pkt(input logic rx, input logic [15:0] len, input logic [2:0] frm,
                     input logic fcs);
    logic [4:0]  e;
    logic [39:0] v;
    logic [15:0] lt;
    state = xs(state);
    lt = ltm == 2'h1 ? 16'h0020 : len - (state[4] ? 16'h0016 : 16'h0012);
    lt = ltm == 2'h0 ? {4'h8, state[27:16]} : lt;
    e = {(|frm) | (fcs_ins & !rx), fcs, len < 16'h0040, ltm == 2'h1,
         len > (rx ? rx_max : tx_max)};
    v = {8'h00, 1'b1, !(|e), state[5:0], |e, 2'b00, e, len};
    @(posedge clk_i);
    if (rx)
    begin
      {rx_pkt_done_i, rx_pkt_len_i, rx_pkt_class_i} <= {1'b1, len, state[5:0]};
      {rx_fcs_err_i, rx_delin_err_i, rx_len_type_i} <= {fcs, frm[0], lt};
      rxq.push_back(v);
      n_rx++;
    end
    else
    begin
      {tx_pkt_done_i, tx_pkt_len_i, tx_pkt_class_i} <= {1'b1, len, state[5:0]};
      {tx_fcs_err_i, tx_proto_err_i, tx_underrun_i, tx_overflow_i} <= {fcs, frm};
      tx_len_type_i <= lt;
      txq.push_back(v);
      n_tx++;
    end
    @(posedge clk_i);
    {tx_pkt_done_i, rx_pkt_done_i, tx_proto_err_i, tx_underrun_i, tx_overflow_i} <= 5'h00;
    rx_delin_err_i <= 1'b0;
  endtask

  task automatic irq_chk(input logic e);
    @(posedge clk_i);
    @(negedge clk_i);
    chk_word({31'h0, e}, {31'h0, irq_o});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i)
    rd_seen <= reg_rd_i;

  always @(negedge clk_i)
  begin
    if (rd_seen === 1'b1)
      chk_word(rdq.pop_front(), reg_rdata_o);
    if (tx_stats_vector_o[31] === 1'b1)
      chk_vec(txq.size() != 0 ? txq.pop_front() : 40'h0, tx_stats_vector_o);
    if (rx_stats_vector_o[31] === 1'b1)
      chk_word({31'h0, rxq.size() != 0 && rxq[0][17]}, {31'h0, rx_len_drop_o});
    if (rx_stats_vector_o[31] === 1'b1)
      chk_vec(rxq.size() != 0 ? rxq.pop_front() : 40'h0, rx_stats_vector_o);
  end

  initial
  begin
    {clk_i, rstn_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, rd_seen, fcs_ins, ltm} = '0;
    {tx_pkt_done_i, tx_pkt_len_i, tx_len_type_i, tx_pkt_class_i, tx_fcs_err_i} = '0;
    {tx_proto_err_i, tx_underrun_i, tx_overflow_i, rx_pkt_done_i, rx_pkt_len_i} = '0;
    {rx_len_type_i, rx_pkt_class_i, rx_fcs_err_i, rx_delin_err_i, tx_preamble_i} = '0;
    {local_fault_i, remote_fault_i, idle_req_i, n_tx, n_rx, mismatches, checks_done} = '0;
    {tx_max, rx_max, state} = {16'h05EE, 16'h05EE, 32'h96EB1D6A};
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    tx_preamble_i <= {state, state[23:0]};
    repeat (3) @(posedge clk_i);
    reg_op(1'b0, mac_stats_pkg::TX_MAX_ADDR, 32'h000005EE);
    reg_op(1'b0, mac_stats_pkg::BUILD_ADDR, 32'h00201848);
    reg_op(1'b1, 8'h40, 32'hFFFFFFFF);
    reg_op(1'b0, 8'h40, 32'h00000000);
    chk_word(32'h0, {31'h0, tx_preamble_en_o} | tx_preamble_o[31:0]);
    pkt(1'b0, 16'h003F, 3'h0, 1'b0);
    pkt(1'b1, 16'h0040, 3'h0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      state = xs(state);
      pkt(i[0], {5'h0, state[10:0]} + 16'h0040, 3'h0, state[12]);
    end
    for (int k = 0; k < 3; k++)
      pkt(1'b0, 16'h0100, 3'b001 << k, 1'b0);
    pkt(1'b1, 16'h0100, 3'h1, 1'b0);
    pkt(1'b1, 16'h0100, 3'h0, 1'b1);
    for (int j = 0; j < 4; j++)
    begin
      ltm = {j[1], !j[1]};
      pkt(j[0], 16'h0100, 3'h0, 1'b0);
    end
    ltm = 2'h0;
    reg_op(1'b1, mac_stats_pkg::CTRL_ADDR, 32'h00000001);
    fcs_ins = 1'b1;
    pkt(1'b0, 16'h0100, 3'h0, 1'b0);
    reg_op(1'b1, mac_stats_pkg::CTRL_ADDR, 32'h00000000);
    tx_underrun_i <= 1'b1;
    pkt(1'b0, 16'h0100, 3'h0, 1'b0);
    fcs_ins = 1'b0;
    reg_op(1'b1, mac_stats_pkg::RX_MAX_ADDR, 32'h00000064);
    rx_max = 16'h0064;
    pkt(1'b1, 16'h0064, 3'h0, 1'b0);
    pkt(1'b1, 16'h0065, 3'h0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      {local_fault_i, remote_fault_i, idle_req_i} <= i[2:0];
      @(posedge clk_i);
      @(negedge clk_i);
      chk_word({30'h0, i[2] ? 2'b10 : i[1] ? 2'b11 : {1'b0, i[0]}}, {30'h0, tx_fault_state_o});
    end
    @(posedge clk_i);
    {local_fault_i, remote_fault_i, idle_req_i} <= 3'h0;
    reg_op(1'b1, mac_stats_pkg::CTRL_ADDR, 32'h0000000C);
    reg_op(1'b0, mac_stats_pkg::FAULT_ADDR, 32'h00000003);
    reg_op(1'b1, mac_stats_pkg::CTRL_ADDR, 32'h00000000);
    reg_op(1'b1, mac_stats_pkg::IRQ_MSK_ADDR, 32'h00000001);
    reg_op(1'b1, mac_stats_pkg::IRQ_ST_ADDR, 32'h0000001F);
    reg_op(1'b0, mac_stats_pkg::IRQ_ST_ADDR, 32'h00000000);
    irq_chk(1'b0);
    pkt(1'b0, 16'h0100, 3'h0, 1'b0);
    reg_op(1'b0, mac_stats_pkg::IRQ_ST_ADDR, 32'h00000001);
    irq_chk(1'b1);
    reg_op(1'b1, mac_stats_pkg::IRQ_MSK_ADDR, 32'h00000000);
    irq_chk(1'b0);
    reg_op(1'b1, mac_stats_pkg::IRQ_MSK_ADDR, 32'h00000001);
    irq_chk(1'b1);
    reg_op(1'b1, mac_stats_pkg::IRQ_ST_ADDR, 32'h00000001);
    irq_chk(1'b0);
    for (int t = 0; t < 50 && txq.size() + rxq.size() + rdq.size() != 0; t++)
      @(posedge clk_i);
    if (txq.size() + rxq.size() + rdq.size() != 0)
      $display("[FAIL] %0t results never appeared", $time);
    if (txq.size() + rxq.size() + rdq.size() != 0)
      mismatches++;
    @(negedge clk_i);
    chk_word(n_tx, tx_pkts);
    chk_word(n_rx, rx_pkts);
    tally_and_finish;
  end
endmodule
`default_nettype wire
